// file: logic/hpi_top.sv
// Notes on behaviour
// - narrow mode moves each word as two bytes, half select marks byte
// - narrow mode has address, data and control registers; control shared
// - narrow mode offers autoincrement sequential and random-access transfers
// - narrow mode can interrupt the host and the processor core
// - all on-chip RAM is reached through the internal DMA bus
// - host transfers continue while the core is halted by emulation
// - wide mode uses separate 16-bit address and 16-bit data buses
// - wide mode holds ready low until the DMA access completes
// - every host access is resynchronised to the processor clock
// - on same-location contention port wins, core waits one cycle
// - wide mode loads address from address bus, data over data bus
// - control register is unreachable by the host in wide mode
// - every wide-mode host access launches a DMA read or write
// - keeper always on in wide mode, else follows keeper enable bit
`timescale 1ns/1ps
module hpi_top
  import hpi_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wide_host_select,
  input wire logic port_chip_select_n,
  input wire logic data_strobe_one_n,
  input wire logic data_strobe_two_n,
  input wire logic read_write_select,
  input wire logic byte_half_select,
  input wire logic [1:0] access_type_select,
  input wire logic [15:0] host_address_bus,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe_n,
  output logic host_ready_out,
  output logic host_int_n,
  output logic keeper_on,
  output logic dma_req,
  output logic dma_we,
  output logic [ADDR_W-1:0] dma_addr,
  output logic [15:0] dma_wdata,
  input wire logic [15:0] dma_rdata,
  input wire logic dma_ack,
  input wire logic core_req,
  input wire logic [ADDR_W-1:0] core_addr,
  output logic core_wait,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [PIN_W-1:0] s1_ff, s2_ff, s3_ff, filt_ff;
  logic strb, strb_d_ff, strb_rise, wide, is_read, byte_hi;
  logic [1:0] acc;
  hpi_state_t state_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [2:0] ctrl_ff;
  logic [15:0] wbuf_ff, rbuf_ff;
  logic incr_pend_ff, dma_req_ff, dma_we_ff;
  logic [15:0] dout_ff;
  logic oe_n_ff, ready_ff, keeper_ff, wait_ff, irq_ff, kcfg_ff, hint_n_ff;
  logic [NUM_EV-1:0] sts_ff, en_ff, ev;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, apb_wr, apb_rd_phase, mapped;
  logic host_wr_ctrl, need_dma;

  // three-stage capture of all host pins; a bit moves when stages 2 and 3 agree
  always_ff @(posedge sys_clk) begin
    s1_ff <= {port_chip_select_n, data_strobe_one_n, data_strobe_two_n,
              read_write_select, byte_half_select, access_type_select,
              host_address_bus, host_data_in, wide_host_select};
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filt_ff <= {3'b111, {(PIN_W-3){1'b0}}};
    end else begin
      filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
    end
  end

  assign wide = filt_ff[P_STRAP];
  assign strb = !filt_ff[P_CS] && (!filt_ff[P_DS1] || !filt_ff[P_DS2]);
  assign strb_rise = strb && !strb_d_ff;
  assign is_read = filt_ff[P_RW];
  assign acc = filt_ff[P_ACC+1:P_ACC];
  assign byte_hi = filt_ff[P_HALF] ^ ctrl_ff[CTL_BYTE_ORDER];
  assign host_wr_ctrl = strb_rise && !wide && !is_read && acc == ACC_CTRL
    && state_ff == ST_IDLE;
  // data access needs DMA: wide always, narrow on write 2nd / read 1st byte
  assign need_dma = wide || (acc[0] &&
    (is_read ? !filt_ff[P_HALF] : filt_ff[P_HALF]));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strb_d_ff <= 1'b0;
    end else begin
      strb_d_ff <= strb;
    end
  end

  // access sequencer and DMA requester; no core halt input gates it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      dma_req_ff <= 1'b0;
      dma_we_ff <= 1'b0;
      ready_ff <= 1'b1;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (strb_rise && need_dma) begin
            state_ff <= ST_DMA;
            dma_req_ff <= 1'b1;
            dma_we_ff <= !is_read;
            ready_ff <= 1'b0;
          end else if (strb_rise) begin
            state_ff <= ST_HOLD;
          end
        end
        ST_DMA: begin
          if (dma_ack) begin
            state_ff <= ST_HOLD;
            dma_req_ff <= 1'b0;
            ready_ff <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (!strb) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          dma_req_ff <= 1'b0;
          ready_ff <= 1'b1;
        end
      endcase
    end
  end

  // address register: wide loads from bus, narrow bytewise or autoincrement
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_ff <= ADDR_W'(ADDR_RST);
      incr_pend_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && strb_rise) begin
      if (wide) begin
        addr_ff <= ADDR_W'(filt_ff[P_ADDR+15:P_ADDR]);
      end else if (!is_read && acc == ACC_ADDR) begin
        if (byte_hi) begin
          addr_ff <= ADDR_W'({filt_ff[P_DATA+7:P_DATA], addr_ff[7:0]});
        end else begin
          addr_ff <= ADDR_W'({addr_ff[15:8], filt_ff[P_DATA+7:P_DATA]});
        end
      end else if (acc == ACC_DATA_INC && filt_ff[P_HALF]) begin
        if (is_read) begin
          addr_ff <= addr_ff + ADDR_W'(1);
        end else begin
          incr_pend_ff <= 1'b1;
        end
      end
    end else if (state_ff == ST_DMA && dma_ack && incr_pend_ff) begin
      addr_ff <= addr_ff + ADDR_W'(1);
      incr_pend_ff <= 1'b0;
    end
  end

  // write assembly and read buffer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wbuf_ff <= 16'h0000;
      rbuf_ff <= 16'h0000;
    end else if (state_ff == ST_IDLE && strb_rise && !is_read) begin
      if (wide) begin
        wbuf_ff <= filt_ff[P_DATA+15:P_DATA];
      end else if (byte_hi) begin
        wbuf_ff[15:8] <= filt_ff[P_DATA+7:P_DATA];
      end else begin
        wbuf_ff[7:0] <= filt_ff[P_DATA+7:P_DATA];
      end
    end else if (state_ff == ST_DMA && dma_ack && !dma_we_ff) begin
      rbuf_ff <= dma_rdata;
    end
  end

  // output driver: enable low only while a read is being answered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dout_ff <= 16'h0000;
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= !(state_ff == ST_HOLD && strb && is_read);
      if (wide) begin
        dout_ff <= rbuf_ff;
      end else begin
        case (acc)
          ACC_CTRL: dout_ff <= {13'h0, ctrl_ff};
          ACC_ADDR: dout_ff <= {8'h00,
            byte_hi ? 8'(addr_ff >> 8) : addr_ff[7:0]};
          default: dout_ff <= {8'h00,
            byte_hi ? rbuf_ff[15:8] : rbuf_ff[7:0]};
        endcase
      end
    end
  end

  // APB slave, one wait state
  assign mapped = paddr == REG_CTRL || paddr == REG_STS || paddr == REG_CLR
    || paddr == REG_EN || paddr == REG_CFG || paddr == REG_STATE;
  assign apb_wr = psel && penable && pready_ff && pwrite && mapped;
  assign apb_rd_phase = psel && penable && !pready_ff;

  // control register: host sets byte order and clears host request, core sets host request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
    end else begin
      if (host_wr_ctrl) begin
        ctrl_ff[CTL_BYTE_ORDER] <= filt_ff[P_DATA+CTL_BYTE_ORDER];
        if (filt_ff[P_DATA+CTL_HOST_INT]) begin
          ctrl_ff[CTL_HOST_INT] <= 1'b0;
        end
      end
      if (apb_wr && paddr == REG_CTRL && pwdata[CTL_HOST_INT]) begin
        ctrl_ff[CTL_HOST_INT] <= 1'b1;
      end
    end
  end

  assign ev[EV_DSP_INT] = host_wr_ctrl && filt_ff[P_DATA+CTL_DSP_INT];
  assign ev[EV_XFER_DONE] = state_ff == ST_DMA && dma_ack;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sts_ff <= '0;
      en_ff <= '0;
      kcfg_ff <= 1'b0;
    end else begin
      sts_ff <= (sts_ff & ~((apb_wr && paddr == REG_CLR) ?
        pwdata[NUM_EV-1:0] : '0)) | ev;
      if (apb_wr && paddr == REG_EN) begin
        en_ff <= pwdata[NUM_EV-1:0];
      end
      if (apb_wr && paddr == REG_CFG) begin
        kcfg_ff <= pwdata[CFG_KEEPER];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= apb_rd_phase;
      pslverr_ff <= apb_rd_phase && !mapped;
      if (apb_rd_phase) begin
        case (paddr)
          REG_CTRL: prdata_ff <= {29'h0, ctrl_ff};
          REG_STS: prdata_ff <= {30'h0, sts_ff};
          REG_EN: prdata_ff <= {30'h0, en_ff};
          REG_CFG: prdata_ff <= {31'h0, kcfg_ff};
          REG_STATE: prdata_ff <= {29'h0, state_ff, wide};
          default: prdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // misc registered outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      keeper_ff <= 1'b0;
      wait_ff <= 1'b0;
      irq_ff <= 1'b0;
      hint_n_ff <= 1'b1;
    end else begin
      keeper_ff <= wide || kcfg_ff;
      wait_ff <= dma_req_ff && core_req && core_addr == addr_ff
        && !wait_ff;
      irq_ff <= |(sts_ff & en_ff);
      hint_n_ff <= !ctrl_ff[CTL_HOST_INT];
    end
  end

  assign host_data_out = dout_ff;
  assign host_data_oe_n = oe_n_ff;
  assign host_ready_out = ready_ff;
  assign host_int_n = hint_n_ff;
  assign keeper_on = keeper_ff;
  assign dma_req = dma_req_ff;
  assign dma_we = dma_we_ff;
  assign dma_addr = addr_ff;
  assign dma_wdata = wbuf_ff;
  assign core_wait = wait_ff;
  assign irq = irq_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  a_ready_stall: assert property (@(posedge sys_clk) disable iff (rst)
    dma_req_ff |-> !ready_ff) else $error("ready high during DMA");
  a_ack_release: assert property (@(posedge sys_clk) disable iff (rst)
    dma_req_ff && dma_ack |=> !dma_req_ff && ready_ff)
    else $error("ack did not end request");
  a_wide_launch: assert property (@(posedge sys_clk) disable iff (rst)
    state_ff == ST_IDLE && strb_rise && wide |=> dma_req_ff
    && dma_we == !$past(is_read)) else $error("wide access without DMA");
  a_wide_addr: assert property (@(posedge sys_clk) disable iff (rst)
    state_ff == ST_IDLE && strb_rise && wide
    |=> addr_ff == $past(ADDR_W'(filt_ff[P_ADDR+15:P_ADDR])))
    else $error("address not loaded");
  a_ctrl_hidden: assert property (@(posedge sys_clk) disable iff (rst)
    wide && !(apb_wr && paddr == REG_CTRL) |=> $stable(ctrl_ff))
    else $error("control changed in wide mode");
  a_keeper_follow: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 keeper_on == ($past(wide) || $past(kcfg_ff)))
    else $error("keeper wrong");
  a_core_wait: assert property (@(posedge sys_clk) disable iff (rst)
    wait_ff |=> !wait_ff) else $error("core waited over one cycle");
  a_auto_inc: assert property (@(posedge sys_clk) disable iff (rst)
    state_ff == ST_IDLE && strb_rise && !wide && is_read
    && acc == ACC_DATA_INC && filt_ff[P_HALF]
    |=> addr_ff == $past(addr_ff) + ADDR_W'(1)) else $error("no increment");
  a_strobe_start: assert property (@(posedge sys_clk) disable iff (rst)
    state_ff == ST_IDLE && !strb |=> state_ff == ST_IDLE)
    else $error("access without strobe");
endmodule : hpi_top

// file: logic/hpi_pkg.sv
package hpi_pkg;
  // register offsets on the processor-side bus
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STS = 8'h04;
  localparam logic [7:0] REG_CLR = 8'h08;
  localparam logic [7:0] REG_EN = 8'h0C;
  localparam logic [7:0] REG_CFG = 8'h10;
  localparam logic [7:0] REG_STATE = 8'h14;
  // access types in narrow mode
  localparam logic [1:0] ACC_CTRL = 2'h0;
  localparam logic [1:0] ACC_DATA_INC = 2'h1;
  localparam logic [1:0] ACC_ADDR = 2'h2;
  localparam logic [1:0] ACC_DATA = 2'h3;
  // control register fields
  localparam int CTL_BYTE_ORDER = 0;
  localparam int CTL_DSP_INT = 1;
  localparam int CTL_HOST_INT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // event bits in status, clear and enable
  localparam int EV_DSP_INT = 0;
  localparam int EV_XFER_DONE = 1;
  localparam int NUM_EV = 2;
  localparam int CFG_KEEPER = 0;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  // pin vector layout after synchronisation
  localparam int PIN_W = 40;
  localparam int P_STRAP = 0;
  localparam int P_DATA = 1;
  localparam int P_ADDR = 17;
  localparam int P_ACC = 33;
  localparam int P_HALF = 35;
  localparam int P_RW = 36;
  localparam int P_DS2 = 37;
  localparam int P_DS1 = 38;
  localparam int P_CS = 39;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DMA = 2'b01,
    ST_HOLD = 2'b10
  } hpi_state_t;
endpackage : hpi_pkg

// file: bench/hpi_mem_model.sv
`timescale 1ns/1ps
module hpi_mem_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] lat,
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [15:0] dma_addr,
  input wire logic [15:0] dma_wdata,
  output logic [15:0] dma_rdata,
  output logic dma_ack
);
  logic [15:0] mem_ff [256];
  logic [3:0] cnt_ff;
  logic done_ff;
  // one ack per request after lat cycles; read data toggles when stale
  always_ff @(posedge sys_clk) begin
    dma_ack <= 1'h0;
    dma_rdata <= ~dma_rdata;
    if (rst || !dma_req) begin
      cnt_ff <= 4'h0;
      done_ff <= 1'h0;
      if (rst) dma_rdata <= 16'h5A5A;
    end else if (!done_ff) begin
      if (cnt_ff == lat) begin
        dma_ack <= 1'h1;
        done_ff <= 1'h1;
        dma_rdata <= mem_ff[dma_addr[7:0]];
        if (dma_we) mem_ff[dma_addr[7:0]] <= dma_wdata;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
endmodule : hpi_mem_model

// file: bench/host_port_interface_test.sv
`timescale 1ns/1ps
module host_port_interface_test
  import hpi_pkg::*;
;
  logic sys_clk = 1'h0, rst = 1'h1, wide = 1'h0, cs_n = 1'h1;
  logic ds1_n = 1'h1, ds2_n = 1'h1, rw = 1'h0, half = 1'h0;
  logic core_req = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [1:0] typ = 2'h0;
  logic [15:0] haddr = 16'h0000, hdrv = 16'h0000, core_addr = 16'h0000;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, rd, prdata;
  logic [3:0] lat = 4'h2;
  logic [15:0] hdout, dma_addr, dma_wdata, dma_rdata;
  logic oe_n, rdy, hint_n, keep, dma_req, dma_we, dma_ack, cwait, irq;
  logic pready, perr;
  wire [15:0] hbus = !oe_n ? hdout : hdrv;
  int fails = 0, comparisons = 0;
  always #12.5 sys_clk = ~sys_clk;
  hpi_top uut (
    .sys_clk(sys_clk), .rst(rst), .wide_host_select(wide),
    .port_chip_select_n(cs_n), .data_strobe_one_n(ds1_n),
    .data_strobe_two_n(ds2_n), .read_write_select(rw),
    .byte_half_select(half), .access_type_select(typ),
    .host_address_bus(haddr), .host_data_in(hbus), .host_data_out(hdout),
    .host_data_oe_n(oe_n), .host_ready_out(rdy), .host_int_n(hint_n),
    .keeper_on(keep), .dma_req(dma_req), .dma_we(dma_we),
    .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata),
    .dma_ack(dma_ack), .core_req(core_req), .core_addr(core_addr),
    .core_wait(cwait), .irq(irq), .psel(psel), .penable(pen),
    .pwrite(pwr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(perr)
  );
  hpi_mem_model mem (
    .sys_clk(sys_clk), .rst(rst), .lat(lat), .dma_req(dma_req),
    .dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
    .dma_rdata(dma_rdata), .dma_ack(dma_ack)
  );
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    pen <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    chk("pready", 1, pready);
    rd = prdata;
    e = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    logic e;
    apb(1'h0, a, 32'h0, e);
    chk("register", x, rd);
  endtask : rchk
  task automatic host(input logic r, input logic [1:0] t, input logic h,
                      input logic [15:0] a, input logic [15:0] d,
                      input logic dma, input logic [15:0] x);
    int n;
    logic low;
    n = 0;
    low = 1'h0;
    @(posedge sys_clk);
    rw <= r;
    typ <= t;
    half <= h;
    haddr <= a;
    hdrv <= d;
    cs_n <= 1'h0;
    if (r) ds2_n <= 1'h0;
    else ds1_n <= 1'h0;
    repeat (3) @(posedge sys_clk);
    do begin
      @(posedge sys_clk);
      n++;
      if (rdy === 1'h0) low = 1'h1;
    end while (!(low && rdy === 1'h1) && n < 30);
    chk("dma launched", dma, low);
    if (r) begin
      n = 0;
      while (oe_n !== 1'h0 && n < 20) begin
        @(posedge sys_clk);
        n++;
      end
      chk("drive enable", 0, oe_n);
      chk("read data", x, wide ? hdout : {8'h00, hdout[7:0]});
    end
    cs_n <= 1'h1;
    ds1_n <= 1'h1;
    ds2_n <= 1'h1;
    repeat (8) @(posedge sys_clk);
  endtask : host
  task automatic t_apb;
    logic e;
    rchk(REG_CFG, 32'h0);
    apb(1'h0, 8'hFC, 32'h0, e);
    chk("slave error", 1, e);
    $display("test apb done");
  endtask : t_apb
  task automatic t_narrow;
    logic e;
    chk("keeper", 0, keep);
    apb(1'h1, REG_CFG, 32'h1, e);
    repeat (2) @(posedge sys_clk);
    chk("keeper", 1, keep);
    host(0, ACC_ADDR, 0, 0, 16'h0040, 0, 0);
    host(0, ACC_ADDR, 1, 0, 16'h0000, 0, 0);
    host(0, ACC_DATA_INC, 0, 0, 16'h0034, 0, 0);
    host(0, ACC_DATA_INC, 1, 0, 16'h0012, 1, 0);
    host(0, ACC_DATA, 0, 0, 16'h00CD, 0, 0);
    host(0, ACC_DATA, 1, 0, 16'h00AB, 1, 0);
    chk("mem 40", 16'h1234, mem.mem_ff[8'h40]);
    chk("mem 41", 16'hABCD, mem.mem_ff[8'h41]);
    host(0, ACC_ADDR, 0, 0, 16'h0040, 0, 0);
    host(0, ACC_ADDR, 1, 0, 16'h0000, 0, 0);
    host(1, ACC_DATA_INC, 0, 0, 0, 1, 16'h0034);
    host(1, ACC_DATA_INC, 1, 0, 0, 0, 16'h0012);
    host(1, ACC_DATA, 0, 0, 0, 1, 16'h00CD);
    $display("test narrow done");
  endtask : t_narrow
  task automatic t_irq;
    logic e;
    apb(1'h1, REG_CLR, 32'h3, e);
    apb(1'h1, REG_EN, 32'h0, e);
    host(0, ACC_CTRL, 0, 0, 16'h0002, 0, 0);
    rchk(REG_STS, 32'h1);
    chk("irq masked", 0, irq);
    apb(1'h1, REG_EN, 32'h1, e);
    repeat (2) @(posedge sys_clk);
    chk("irq", 1, irq);
    apb(1'h1, REG_CLR, 32'h1, e);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 0, irq);
    apb(1'h1, REG_CTRL, 32'h4, e);
    repeat (2) @(posedge sys_clk);
    chk("host int", 0, hint_n);
    host(0, ACC_CTRL, 0, 0, 16'h0004, 0, 0);
    chk("host int", 1, hint_n);
    $display("test irq done");
  endtask : t_irq
  task automatic t_wide;
    int n, k;
    logic e;
    wide <= 1'h1;
    lat <= 4'h5;
    apb(1'h1, REG_CLR, 32'h3, e);
    apb(1'h1, REG_CFG, 32'h0, e);
    repeat (6) @(posedge sys_clk);
    chk("keeper", 1, keep);
    fork
      host(0, ACC_CTRL, 0, 16'h0012, 16'hA5C3, 1, 0);
      begin
        n = 0;
        k = 0;
        while (dma_req !== 1'h1 && n < 40) begin
          @(posedge sys_clk);
          n++;
        end
        core_addr <= 16'h0012;
        core_req <= 1'h1;
        // core access ends once it has waited
        repeat (4) begin
          @(posedge sys_clk);
          k += int'(cwait === 1'h1);
          if (k > 0 && core_req) core_req <= 1'h0;
        end
        if (core_req) core_req <= 1'h0;
      end
    join
    chk("core wait cycles", 1, k);
    chk("mem 12", 16'hA5C3, mem.mem_ff[8'h12]);
    rchk(REG_STS, 32'h2);
    rchk(REG_STATE, 32'h1);
    lat <= 4'h0;
    host(1, ACC_DATA, 0, 16'h0012, 0, 1, 16'hA5C3);
    $display("test wide done");
  endtask : t_wide
  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'h0;
    t_apb;
    t_narrow;
    t_irq;
    t_wide;
    stop_test;
  end
endmodule : host_port_interface_test
